// ==== include/spg_pkg.sv ====
// What this block does
// R1: Manual keys or typed commands start, stop spindle.
// R2: Stop key while stopped toggles jog state.
// R3: Jog key runs spindle timed, stop ends early.
// R4: Jog state ignores typed spindle commands.
// R5: Clamped chuck with interlock refuses start, alarms.
// R6: Interlocked chuck operation refused during clockwise rotation.
// R7: Interlocked tailstock operation refused while rotating.
// R8: Style bit selects level or pulse outputs.
// R9: Pulse outputs last the pulse hold time.
// R10: Brake asserts after brake delay following stop.
// R11: Brake holds for brake duration, then releases.
// R12: Without variable drive, S word selects gear.
// R13: Line mode accepts gears 0-4, gear 0 clears.
// R14: Coded mode accepts 0-15, binary, line one LSB.
// R15: Only configured line count is driven.
// R16: Coded mode with few lines drives low bits.
// R17: Reset selects gear 0, all lines off.
// R18: Line mode latches one line, clears others.
// R19: Gear 0 deasserts all gear lines.
// R20: Switch interval between release and new gear.
// R21: Gear key advances gear cyclically with wrap.
// R22: Variable drive takes gears from gear commands.
// R23: Each gear command maps to one line.
// R24: Level outputs held, released before direction change.
// R25: Sticky alarm flag with cause for refusals.
package spg_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;

  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_CMD = 6'h04;
  localparam logic [5:0] OFS_SET0 = 6'h08;
  localparam logic [5:0] OFS_STATUS = 6'h20;
  localparam logic [5:0] OFS_ALARM = 6'h24;
  localparam logic [5:0] OFS_SPEED = 6'h28;

  localparam int CTL_STYLE = 0;
  localparam int CTL_CHUCK = 1;
  localparam int CTL_TAIL = 2;
  localparam int CTL_VDRV = 3;
  localparam int CTL_CODE = 4;
  localparam int CTL_LINES = 5;
  localparam logic [7:0] CTRL_RST = 8'h80;

  localparam int SET_JOG_SPD = 0;
  localparam int SET_JOG_TIME = 1;
  localparam int SET_PULSE = 2;
  localparam int SET_BRK_DLY = 3;
  localparam int SET_BRK_DUR = 4;
  localparam int SET_GEAR_GAP = 5;
  localparam logic [15:0] SET_RST [6] = '{16'h0000, 16'h03e8, 16'h0064,
                                          16'h0064, 16'h01f4, 16'h0064};

  localparam int T_PULSE = 0;
  localparam int T_BRAKE = 1;
  localparam int T_JOG = 2;
  localparam int T_GEAR = 3;

  localparam logic [1:0] ALM_START = 2'h1;
  localparam logic [1:0] ALM_CHUCK = 2'h2;
  localparam logic [1:0] ALM_TAIL = 2'h3;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_CW = 4'h1, OP_CCW = 4'h2, OP_STOP = 4'h3,
    OP_SWORD = 4'h4, OP_GEAR = 4'h5, OP_CHUCK = 4'h6, OP_TAIL = 4'h7
  } spg_op_e;

  typedef enum logic [1:0] {
    DIR_NONE = 2'h0, DIR_CW = 2'h1, DIR_CCW = 2'h2
  } spg_dir_e;

  typedef enum logic [1:0] {
    SP_IDLE = 2'b00, SP_RUN = 2'b01, SP_GAP = 2'b11
  } spg_sp_e;

  typedef enum logic [1:0] {
    BRK_NONE = 2'b00, BRK_DLY = 2'b01, BRK_ON = 2'b11
  } spg_brk_e;

  typedef enum logic {
    GR_IDLE = 1'b0, GR_GAP = 1'b1
  } spg_gr_e;
endpackage

// ==== logic/spg_core.sv ====
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module spg_core #(
  parameter int TICK_CYCLES = spg_pkg::TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic key_cw_pin,
  input wire logic key_ccw_pin,
  input wire logic key_stop_pin,
  input wire logic key_gear_pin,
  input wire logic chuck_clamped_pin,
  output logic spin_cw,
  output logic spin_ccw,
  output logic spin_stop,
  output logic brake_output,
  output logic spin_led,
  output logic jog_flag,
  output logic [15:0] jog_speed,
  output logic [3:0] gear_lines,
  output logic [3:0] gear_line_en,
  output logic chuck_go,
  output logic tail_go,
  output logic alarm,
  output logic [1:0] alarm_cause,
  output logic [15:0] speed_word
);
  // ----------------------------------------
  // Pin synchronisers and key edges.
  // ----------------------------------------
  logic [4:0] sy1_q, sy2_q, sy3_q;
  wire [4:0] pins = {chuck_clamped_pin, key_gear_pin, key_stop_pin,
                     key_ccw_pin, key_cw_pin};
  wire [3:0] kedge = sy2_q[3:0] & ~sy3_q[3:0];
  wire clamped = sy2_q[4];
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sy1_q <= 5'h00;
      sy2_q <= 5'h00;
      sy3_q <= 5'h00;
    end else begin
      sy1_q <= pins;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  // ----------------------------------------
  // Millisecond tick.
  // ----------------------------------------
  logic [15:0] tick_cnt_q;
  logic tick_q;
  wire tick_wrap = tick_cnt_q == 16'(TICK_CYCLES - 1);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tick_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_wrap ? 16'h0000 : tick_cnt_q + 16'h0001;
      tick_q <= tick_wrap;
    end
  end

  // ----------------------------------------
  // Avalon slave and registers.
  // ----------------------------------------
  logic [7:0] ctrl_q;
  logic [15:0] set_q [6];
  logic [3:0] tmr_exp;
  wire [31:0] be_m = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] wdm = avs_writedata & be_m;
  wire bus_req = avs_read | avs_write;
  wire wr_en = avs_write & ~avs_waitrequest;
  wire [3:0] widx = avs_address[5:2];
  wire sel_ctrl = avs_address == spg_pkg::OFS_CTRL;
  wire sel_cmd = avs_address == spg_pkg::OFS_CMD;
  wire sel_set = widx >= spg_pkg::OFS_SET0[5:2] && widx <= 4'h7;
  wire sel_stat = avs_address == spg_pkg::OFS_STATUS;
  wire sel_alm = avs_address == spg_pkg::OFS_ALARM;
  wire sel_spd = avs_address == spg_pkg::OFS_SPEED;
  wire [2:0] set_idx = 3'(widx - spg_pkg::OFS_SET0[5:2]);
  wire [3:0] cmd_op = (wr_en & sel_cmd & avs_byteenable[0]) ?
                      avs_writedata[3:0] : spg_pkg::OP_NONE;
  wire [15:0] cmd_val = avs_writedata[23:8];
  wire style = ctrl_q[spg_pkg::CTL_STYLE];
  wire code = ctrl_q[spg_pkg::CTL_CODE];
  wire vdrv = ctrl_q[spg_pkg::CTL_VDRV];
  wire [2:0] lines = ctrl_q[7:5];
  logic [31:0] rd_mux;
  logic [31:0] status_w;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (bus_req & avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_mux = {24'h00_0000, ctrl_q};
    end else if (sel_set) begin
      rd_mux = {16'h0000, set_q[set_idx]};
    end else if (sel_stat) begin
      rd_mux = status_w;
    end else if (sel_alm) begin
      rd_mux = {29'h0000_0000, alarm_cause, alarm};
    end else if (sel_spd) begin
      rd_mux = {16'h0000, speed_word};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_q <= spg_pkg::CTRL_RST;
      for (int i = 0; i < 6; i++) begin
        set_q[i] <= spg_pkg::SET_RST[i];
      end
    end else if (wr_en) begin
      if (sel_ctrl) begin
        ctrl_q <= (ctrl_q & ~be_m[7:0]) | wdm[7:0];
      end
      if (sel_set) begin
        set_q[set_idx] <= (set_q[set_idx] & ~be_m[15:0]) | wdm[15:0];
      end
    end
  end

  // ----------------------------------------
  // Millisecond timers.
  // ----------------------------------------
  logic [3:0] tmr_go, tmr_kill;
  logic [15:0] tmr_ld [4];
  for (genvar i = 0; i < 4; i++) begin : g_tmr
    logic [15:0] cnt_q;
    logic run_q;
    always_ff @(posedge clk_sys) begin
      if (srst || tmr_kill[i]) begin
        cnt_q <= 16'h0000;
        run_q <= 1'b0;
        tmr_exp[i] <= 1'b0;
      end else begin
        tmr_exp[i] <= 1'b0;
        if (tmr_go[i]) begin
          cnt_q <= tmr_ld[i];
          run_q <= 1'b1;
        end else if (run_q && tick_q) begin
          if (cnt_q <= 16'h0001) begin
            run_q <= 1'b0;
            tmr_exp[i] <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Spindle command decode and interlocks.
  // ----------------------------------------
  spg_pkg::spg_dir_e dir_q, pend_q;
  spg_pkg::spg_sp_e sp_q;
  spg_pkg::spg_brk_e brk_q;
  logic jog_q, jog_run_q;
  logic [2:0] pls_q;
  wire stopped = dir_q == spg_pkg::DIR_NONE && sp_q == spg_pkg::SP_IDLE;
  wire t_cw = cmd_op == spg_pkg::OP_CW && !jog_q; // [R1] [R4]
  wire t_ccw = cmd_op == spg_pkg::OP_CCW && !jog_q; // [R4]
  wire t_stop = cmd_op == spg_pkg::OP_STOP && !jog_q; // [R4]
  wire jog_toggle = kedge[2] & stopped; // [R2]
  wire start_cw = t_cw | (kedge[0] & (!jog_q | stopped)); // [R3]
  wire start_ccw = t_ccw | (kedge[1] & (!jog_q | stopped));
  wire blk = !ctrl_q[spg_pkg::CTL_CHUCK] && clamped; // [R5]
  wire alm_start = (start_cw | start_ccw) & blk; // [R5]
  wire do_stop = t_stop | (kedge[2] & !stopped) | tmr_exp[spg_pkg::T_JOG];
  wire go_cw = start_cw & !blk & !do_stop;
  wire go_ccw = start_ccw & !blk & !do_stop & !go_cw;
  wire go_any = (go_cw && dir_q != spg_pkg::DIR_CW) ||
                (go_ccw && dir_q != spg_pkg::DIR_CCW);
  wire stop_eff = do_stop && !stopped;
  wire chuck_req = cmd_op == spg_pkg::OP_CHUCK;
  wire tail_req = cmd_op == spg_pkg::OP_TAIL;
  wire chuck_ref = chuck_req && !ctrl_q[spg_pkg::CTL_CHUCK] &&
                   dir_q == spg_pkg::DIR_CW; // [R6]
  wire tail_ref = tail_req && !ctrl_q[spg_pkg::CTL_TAIL] && !stopped; // [R7]
  wire alm_set = alm_start | chuck_ref | tail_ref;
  wire alm_clr = wr_en & sel_alm & avs_byteenable[0] & avs_writedata[0];
  wire [1:0] alm_c = alm_start ? spg_pkg::ALM_START :
                     chuck_ref ? spg_pkg::ALM_CHUCK : spg_pkg::ALM_TAIL;

  // ----------------------------------------
  // Timer requests.
  // ----------------------------------------
  assign tmr_go[spg_pkg::T_PULSE] = style & (go_any | stop_eff); // [R9]
  assign tmr_ld[spg_pkg::T_PULSE] = set_q[spg_pkg::SET_PULSE];
  assign tmr_kill[spg_pkg::T_PULSE] = 1'b0;
  assign tmr_go[spg_pkg::T_BRAKE] = stop_eff | (brk_q == spg_pkg::BRK_DLY &&
                                    tmr_exp[spg_pkg::T_BRAKE]);
  assign tmr_ld[spg_pkg::T_BRAKE] = stop_eff ? set_q[spg_pkg::SET_BRK_DLY] :
                                    set_q[spg_pkg::SET_BRK_DUR];
  assign tmr_kill[spg_pkg::T_BRAKE] = go_any;
  assign tmr_go[spg_pkg::T_JOG] = go_any & jog_q;
  assign tmr_ld[spg_pkg::T_JOG] = set_q[spg_pkg::SET_JOG_TIME];
  assign tmr_kill[spg_pkg::T_JOG] = stop_eff;

  // ----------------------------------------
  // Spindle direction, pulses, brake and alarm.
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dir_q <= spg_pkg::DIR_NONE;
      pend_q <= spg_pkg::DIR_NONE;
      sp_q <= spg_pkg::SP_IDLE;
      brk_q <= spg_pkg::BRK_NONE;
      jog_q <= 1'b0;
      jog_run_q <= 1'b0;
      pls_q <= 3'h0;
      alarm <= 1'b0;
      alarm_cause <= 2'h0;
    end else begin
      if (jog_toggle) begin
        jog_q <= !jog_q; // [R2]
      end
      if (stop_eff) begin
        dir_q <= spg_pkg::DIR_NONE;
        sp_q <= spg_pkg::SP_IDLE;
        jog_run_q <= 1'b0; // [R3]
        brk_q <= spg_pkg::BRK_DLY; // [R10]
      end else if (go_any) begin
        brk_q <= spg_pkg::BRK_NONE;
        jog_run_q <= jog_q; // [R3]
        if (!style && dir_q != spg_pkg::DIR_NONE) begin
          dir_q <= spg_pkg::DIR_NONE; // [R24]
          pend_q <= go_cw ? spg_pkg::DIR_CW : spg_pkg::DIR_CCW;
          sp_q <= spg_pkg::SP_GAP;
        end else begin
          dir_q <= go_cw ? spg_pkg::DIR_CW : spg_pkg::DIR_CCW; // [R1]
          sp_q <= spg_pkg::SP_RUN;
        end
      end else if (sp_q == spg_pkg::SP_GAP) begin
        dir_q <= pend_q; // [R24]
        sp_q <= spg_pkg::SP_RUN;
      end else if (tmr_exp[spg_pkg::T_BRAKE]) begin
        brk_q <= (brk_q == spg_pkg::BRK_DLY) ? spg_pkg::BRK_ON :
                 spg_pkg::BRK_NONE; // [R10] [R11]
      end
      if (style && (go_any || stop_eff)) begin
        pls_q <= {stop_eff, go_ccw & !stop_eff, go_cw & !stop_eff}; // [R9]
      end else if (tmr_exp[spg_pkg::T_PULSE]) begin
        pls_q <= 3'h0; // [R9]
      end
      if (alm_set) begin
        alarm <= 1'b1; // [R25]
        alarm_cause <= alm_c;
      end else if (alm_clr) begin
        alarm <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Gear selection.
  // ----------------------------------------
  logic [3:0] cur_q, gq_q, gpend_q;
  spg_pkg::spg_gr_e gst_q;
  wire coded = code & !vdrv;
  wire s_ok = coded ? cmd_val <= 16'h000f : cmd_val <= 16'h0004; // [R13] [R14]
  wire s_req = cmd_op == spg_pkg::OP_SWORD && !vdrv && s_ok; // [R12]
  wire m_req = cmd_op == spg_pkg::OP_GEAR && vdrv &&
               cmd_val >= 16'h0001 && cmd_val <= 16'h0004; // [R22]
  wire [3:0] key_next = coded ? cur_q + 4'h1 : // [R21]
                        (cur_q >= 4'h4) ? 4'h1 : cur_q + 4'h1;
  wire g_cmd = s_req | m_req;
  wire g_req = g_cmd | kedge[3];
  wire [3:0] g_new = g_cmd ? cmd_val[3:0] : key_next;
  wire [3:0] g_pat = coded ? g_new : // [R14]
                     (g_new == 4'h0) ? 4'h0 :
                     4'(4'h1 << (g_new - 4'h1)); // [R13] [R18] [R23]
  wire [4:0] lmask5 = 5'(5'h01 << lines) - 5'h01;
  wire [3:0] lmask = (lines >= 3'h4) ? 4'hf : lmask5[3:0]; // [R15] [R16]
  wire g_chg = g_req && g_new != cur_q;
  assign tmr_go[spg_pkg::T_GEAR] = g_chg && g_pat != 4'h0 && gq_q != 4'h0;
  assign tmr_ld[spg_pkg::T_GEAR] = set_q[spg_pkg::SET_GEAR_GAP];
  assign tmr_kill[spg_pkg::T_GEAR] = g_chg && !tmr_go[spg_pkg::T_GEAR];
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cur_q <= 4'h0; // [R17]
      gq_q <= 4'h0;
      gpend_q <= 4'h0;
      gst_q <= spg_pkg::GR_IDLE;
    end else if (g_chg) begin
      cur_q <= g_new;
      gpend_q <= g_pat;
      if (tmr_go[spg_pkg::T_GEAR]) begin
        gq_q <= 4'h0; // [R20]
        gst_q <= spg_pkg::GR_GAP;
      end else begin
        gq_q <= g_pat; // [R19]
        gst_q <= spg_pkg::GR_IDLE;
      end
    end else if (gst_q == spg_pkg::GR_GAP && tmr_exp[spg_pkg::T_GEAR]) begin
      gq_q <= gpend_q; // [R20]
      gst_q <= spg_pkg::GR_IDLE;
    end
  end

  // ----------------------------------------
  // Registered outputs.
  // ----------------------------------------
  assign status_w = {19'h0_0000, gst_q == spg_pkg::GR_GAP, gq_q, cur_q,
                     brake_output, jog_q, dir_q};
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      spin_cw <= 1'b0;
      spin_ccw <= 1'b0;
      spin_stop <= 1'b0;
      brake_output <= 1'b0;
      spin_led <= 1'b0;
      jog_flag <= 1'b0;
      jog_speed <= 16'h0000;
      gear_lines <= 4'h0;
      gear_line_en <= 4'h0;
      chuck_go <= 1'b0;
      tail_go <= 1'b0;
      speed_word <= 16'h0000;
    end else begin
      spin_cw <= style ? pls_q[0] : dir_q == spg_pkg::DIR_CW; // [R8]
      spin_ccw <= style ? pls_q[1] : dir_q == spg_pkg::DIR_CCW; // [R8]
      spin_stop <= style & pls_q[2]; // [R8]
      brake_output <= brk_q == spg_pkg::BRK_ON; // [R11]
      spin_led <= dir_q != spg_pkg::DIR_NONE; // [R1]
      jog_flag <= jog_q; // [R2]
      jog_speed <= jog_run_q ? set_q[spg_pkg::SET_JOG_SPD] : 16'h0000;
      gear_lines <= gq_q & lmask; // [R15] [R16]
      gear_line_en <= lmask;
      chuck_go <= chuck_req & !chuck_ref; // [R6]
      tail_go <= tail_req & !tail_ref; // [R7]
      if (cmd_op == spg_pkg::OP_SWORD && vdrv) begin
        speed_word <= cmd_val; // [R22]
      end
    end
  end

  // ----------------------------------------
  // Assertions.
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_brk_arm;
    brk_q == spg_pkg::BRK_DLY && tmr_exp[spg_pkg::T_BRAKE] && !go_any &&
    !stop_eff;
  endsequence
  a_brake_follows_delay: assert property ( // [R10]
    s_brk_arm |=> brk_q == spg_pkg::BRK_ON ##1 brake_output)
    else $error("Brake did not assert after its delay.");
  a_brake_on_stop: assert property ( // [R10]
    stop_eff |=> brk_q == spg_pkg::BRK_DLY && !brake_output)
    else $error("Stop did not arm the brake delay.");
  a_typed_jog_ignored: assert property ( // [R4]
    jog_q && cmd_op == spg_pkg::OP_CW && kedge[1:0] == 2'h0 && stopped
    |=> dir_q == spg_pkg::DIR_NONE)
    else $error("Typed start was taken in jog state.");
  a_chuck_start_block: assert property ( // [R5]
    alm_start |=> alarm && alarm_cause == spg_pkg::ALM_START &&
    $stable(dir_q))
    else $error("Start with clamped chuck was not refused.");
  a_chuck_op_refuse: assert property ( // [R6]
    chuck_ref |=> !chuck_go && alarm)
    else $error("Chuck operation allowed while turning clockwise.");
  a_tail_op_refuse: assert property ( // [R7]
    tail_ref |=> !tail_go && alarm && alarm_cause != 2'h0)
    else $error("Tailstock operation allowed while rotating.");
  a_level_style_out: assert property ( // [R8]
    !style && dir_q == spg_pkg::DIR_CW && $stable(style) |=> spin_cw)
    else $error("Level output missing while turning clockwise.");
  a_dir_exclusive: assert property ( // [R24]
    !(spin_cw && spin_ccw))
    else $error("Both direction outputs asserted.");
  a_dir_gap_release: assert property ( // [R24]
    sp_q == spg_pkg::SP_GAP |-> dir_q == spg_pkg::DIR_NONE ##1
    dir_q == $past(pend_q))
    else $error("Direction change did not pass through release.");
  a_gear_gap_clear: assert property ( // [R20]
    gst_q == spg_pkg::GR_GAP |-> gq_q == 4'h0)
    else $error("Gear line held during the switch interval.");
  a_gear_one_line: assert property ( // [R18]
    !coded |-> $onehot0(gq_q))
    else $error("More than one gear line asserted.");
  a_gear_mask_lines: assert property ( // [R15]
    (gear_lines & ~gear_line_en) == 4'h0)
    else $error("Gear line driven above the line count.");
endmodule
`default_nettype wire

// ==== tb/spg_drive_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module spg_drive_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic spin_cw,
  input wire logic spin_ccw,
  input wire logic clamp_req,
  output logic chuck_clamped_pin,
  output logic [7:0] clash_cnt
);
  // ------------------------------------------------------------
  // Drive and chuck
  // ------------------------------------------------------------
  // The chuck reports its clamp state a cycle after the request.
  // Both directions driven at once would short the drive contactors.
  always_ff @(posedge clk_sys) begin
    chuck_clamped_pin <= clamp_req;
    if (srst) begin
      clash_cnt <= 8'h00;
    end else if (spin_cw && spin_ccw) begin
      clash_cnt <= clash_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== tb/spindle_run_and_gear_outputs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module spindle_run_and_gear_outputs_tb;
  localparam int TK = 10;
  localparam logic [15:0] SV [6] = '{16'h0055, 16'h0003, 16'h0002,
                                     16'h0002, 16'h0003, 16'h0002};
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] keys = 4'h0;
  logic clamp_req = 1'b0;
  logic chuck_clamped_pin, spin_cw, spin_ccw, spin_stop, brake_output;
  logic spin_led, jog_flag, chuck_go, tail_go, alarm;
  logic [15:0] jog_speed, speed_word;
  logic [3:0] gear_lines, gear_line_en;
  logic [1:0] alarm_cause;
  logic [7:0] clash_cnt;
  logic [8:0] obs;
  logic [31:0] rd;
  int fails = 0;
  int num_checks = 0;
  int n;
  assign obs = {alarm, tail_go, chuck_go, jog_flag, spin_led,
                brake_output, spin_stop, spin_ccw, spin_cw};

  spg_core #(.TICK_CYCLES(TK)) DUT (.clk_sys(clk_sys), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .key_cw_pin(keys[0]),
    .key_ccw_pin(keys[1]), .key_stop_pin(keys[2]),
    .key_gear_pin(keys[3]), .chuck_clamped_pin(chuck_clamped_pin),
    .spin_cw(spin_cw), .spin_ccw(spin_ccw), .spin_stop(spin_stop),
    .brake_output(brake_output), .spin_led(spin_led),
    .jog_flag(jog_flag), .jog_speed(jog_speed), .gear_lines(gear_lines),
    .gear_line_en(gear_line_en), .chuck_go(chuck_go), .tail_go(tail_go),
    .alarm(alarm), .alarm_cause(alarm_cause), .speed_word(speed_word));

  spg_drive_model drive (.clk_sys(clk_sys), .srst(srst),
    .spin_cw(spin_cw), .spin_ccw(spin_ccw), .clamp_req(clamp_req),
    .chuck_clamped_pin(chuck_clamped_pin), .clash_cnt(clash_cnt));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rng(input int v, input int lo, input int hi);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask

  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 50) fails++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic cmd(input logic [3:0] op, input logic [15:0] v);
    bus(1'b1, spg_pkg::OFS_CMD, {8'h00, v, 4'h0, op});
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask

  task automatic waitv(input int b, input logic v);
    #1;
    n = 0;
    while (obs[b] !== v && n < 2000) begin
      settle(1);
      n++;
    end
    chk({31'h0, obs[b]}, {31'h0, v});
  endtask

  task automatic wgear(input logic [3:0] e);
    n = 0;
    while (gear_lines !== e && n < 500) begin
      settle(1);
      n++;
    end
    chk({28'h0, gear_lines}, {28'h0, e});
  endtask

  task automatic key(input int i);
    @(posedge clk_sys);
    keys[i] <= 1'b1;
    repeat (5) @(posedge clk_sys);
    keys[i] <= 1'b0;
    repeat (5) @(posedge clk_sys);
  endtask

  task automatic clamp(input logic v);
    @(posedge clk_sys);
    clamp_req <= v;
    settle(4);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    fails++;
    summarize();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    settle(1);
    chk({28'h0, gear_lines}, 32'h0);
    bus(1'b0, spg_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h80);
    bus(1'b0, 6'h3c, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 6'(spg_pkg::OFS_SET0 + 4 * i), 32'h0);
      chk(rd, {16'h0, spg_pkg::SET_RST[i]});
      bus(1'b1, 6'(spg_pkg::OFS_SET0 + 4 * i), {16'h0, SV[i]});
    end
    cmd(spg_pkg::OP_CW, 16'h0);
    settle(3);
    chk({29'h0, spin_led, spin_ccw, spin_cw}, 32'h5);
    cmd(spg_pkg::OP_CCW, 16'h0);
    settle(4);
    chk({30'h0, spin_ccw, spin_cw}, 32'h2);
    cmd(spg_pkg::OP_STOP, 16'h0);
    settle(3);
    chk({29'h0, spin_stop, spin_ccw, spin_cw}, 32'h0);
    waitv(3, 1'b1);
    rng(n, TK, 3 * TK + 5);
    waitv(3, 1'b0);
    rng(n, 2 * TK, 4 * TK + 5);
    bus(1'b1, spg_pkg::OFS_CTRL, 32'h81);
    cmd(spg_pkg::OP_CW, 16'h0);
    waitv(0, 1'b1);
    waitv(0, 1'b0);
    rng(n, TK, 3 * TK + 5);
    cmd(spg_pkg::OP_STOP, 16'h0);
    waitv(2, 1'b1);
    waitv(2, 1'b0);
    rng(n, TK, 3 * TK + 5);
    waitv(3, 1'b1);
    waitv(3, 1'b0);
    bus(1'b1, spg_pkg::OFS_CTRL, 32'h80);
    key(2);
    waitv(5, 1'b1);
    cmd(spg_pkg::OP_CW, 16'h0);
    settle(4);
    chk({29'h0, spin_led, spin_ccw, spin_cw}, 32'h0);
    key(1);
    waitv(4, 1'b1);
    chk({16'h0, jog_speed}, 32'h55);
    chk({30'h0, spin_ccw, spin_cw}, 32'h2);
    waitv(4, 1'b0);
    rng(n, 2 * TK - 6, 3 * TK);
    waitv(3, 1'b1);
    waitv(3, 1'b0);
    key(0);
    waitv(4, 1'b1);
    key(2);
    waitv(4, 1'b0);
    rng(n, 0, TK);
    waitv(3, 1'b1);
    waitv(3, 1'b0);
    if (jog_flag === 1'b1) key(2);
    waitv(5, 1'b0);
    clamp(1'b1);
    cmd(spg_pkg::OP_CW, 16'h0);
    settle(3);
    chk({31'h0, spin_cw}, 32'h0);
    bus(1'b0, spg_pkg::OFS_ALARM, 32'h0);
    chk(rd, {29'h0, spg_pkg::ALM_START, 1'b1});
    bus(1'b1, spg_pkg::OFS_ALARM, 32'h1);
    settle(1);
    chk({31'h0, alarm}, 32'h0);
    clamp(1'b0);
    cmd(spg_pkg::OP_CW, 16'h0);
    cmd(spg_pkg::OP_CHUCK, 16'h0);
    settle(3);
    chk({29'h0, alarm_cause, alarm}, {29'h0, spg_pkg::ALM_CHUCK, 1'b1});
    cmd(spg_pkg::OP_TAIL, 16'h0);
    settle(3);
    chk({29'h0, alarm_cause, alarm}, {29'h0, spg_pkg::ALM_TAIL, 1'b1});
    cmd(spg_pkg::OP_STOP, 16'h0);
    waitv(3, 1'b1);
    waitv(3, 1'b0);
    cmd(spg_pkg::OP_TAIL, 16'h0);
    waitv(7, 1'b1);
    cmd(spg_pkg::OP_CHUCK, 16'h0);
    waitv(6, 1'b1);
    cmd(spg_pkg::OP_SWORD, 16'h2);
    wgear(4'h2);
    cmd(spg_pkg::OP_SWORD, 16'h3);
    wgear(4'h0);
    wgear(4'h4);
    rng(n, TK, 3 * TK + 5);
    cmd(spg_pkg::OP_SWORD, 16'h5);
    settle(60);
    chk({28'h0, gear_lines}, 32'h4);
    cmd(spg_pkg::OP_SWORD, 16'h0);
    wgear(4'h0);
    bus(1'b1, spg_pkg::OFS_CTRL, 32'h90);
    cmd(spg_pkg::OP_SWORD, 16'hb);
    wgear(4'hb);
    cmd(spg_pkg::OP_SWORD, 16'hf);
    wgear(4'hf);
    key(3);
    wgear(4'h0);
    key(3);
    wgear(4'h1);
    bus(1'b1, spg_pkg::OFS_CTRL, 32'h50);
    cmd(spg_pkg::OP_SWORD, 16'he);
    settle(60);
    chk({28'h0, gear_line_en}, 32'h3);
    chk({30'h0, gear_lines[1:0]}, 32'h2);
    bus(1'b1, spg_pkg::OFS_CTRL, 32'h10);
    settle(3);
    chk({28'h0, gear_line_en}, 32'h0);
    cmd(spg_pkg::OP_SWORD, 16'h0);
    settle(3);
    bus(1'b1, spg_pkg::OFS_CTRL, 32'h80);
    cmd(spg_pkg::OP_SWORD, 16'h4);
    wgear(4'h8);
    key(3);
    wgear(4'h0);
    wgear(4'h1);
    bus(1'b1, spg_pkg::OFS_CTRL, 32'h88);
    cmd(spg_pkg::OP_GEAR, 16'h3);
    wgear(4'h4);
    cmd(spg_pkg::OP_SWORD, 16'h1234);
    settle(3);
    chk({16'h0, speed_word}, 32'h1234);
    chk({28'h0, gear_lines}, 32'h4);
    chk({24'h0, clash_cnt}, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
